// file: core/crcen_engine.v
// crc checksum engine with apb registers, data fifo and byte-per-cycle folding
`timescale 1ns/1ps
`default_nettype none
`include "crcen_map.vh"

module crcen_engine
(
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   output reg [31:0] prdata,
   output wire pready,
   output wire pslverr
);

   // ==========================================================================
   // helpers

   // address decode, shared by the write and read paths
   function [2:0] regSel;
      input [11:0] a;
      begin
         if (a == `CRCEN_OFS_MODE)
            regSel = `CRCEN_SEL_MODE;
         else if (a == `CRCEN_OFS_SEED)
            regSel = `CRCEN_SEL_SEED;
         else if (a == `CRCEN_OFS_SUM)
            regSel = `CRCEN_SEL_SUM;
         else if (a == `CRCEN_OFS_DATA)
            regSel = `CRCEN_SEL_DATA;
         else if (a == `CRCEN_OFS_POLY)
            regSel = `CRCEN_SEL_POLY;
         else if (a == `CRCEN_OFS_STATUS)
            regSel = `CRCEN_SEL_STATUS;
         else
            regSel = `CRCEN_SEL_NONE;
      end
   endfunction

   // bit reversal over 32 bits; 16-bit sums reuse it with a shift
   function [31:0] rev32;
      input [31:0] x;
      integer k;
      begin
         rev32 = 32'h00000000;
         for (k = 0; k < 32; k = k + 1)
            rev32[k] = x[31-k];
      end
   endfunction

   // ==========================================================================
   // state

   reg [`CRCEN_MODE_W-1:0] mode_q;
   reg [31:0] poly_q;
   reg [31:0] crc_q;
   reg [31:0] crc_d;
   reg [23:0] cur_q;
   reg [23:0] cur_d;
   reg [2:0] left_q;
   reg [2:0] left_d;
   reg rdOk_q;
   reg [31:0] rdMux;

   wire [2:0] sel;
   wire access;
   wire wrDone;
   wire busy;
   wire fifoInValid;
   wire fifoInReady;
   wire [`CRCEN_FIFO_W-1:0] fifoInData;
   wire fifoOutValid;
   wire fifoOutReady;
   wire [`CRCEN_FIFO_W-1:0] fifoOutData;
   wire [`CRCEN_FIFO_AW:0] fifoLevel;
   reg [1:0] sizeCode;
   reg writeReady;

   // ==========================================================================
   // apb decode and handshake

   assign sel = regSel(paddr);
   assign access = psel & penable;
   assign busy = fifoOutValid | (left_q != 3'h0);

   // write strobes give the width of a data write; odd patterns count as word
   always @*
   begin
      if (pstrb == 4'h1)
         sizeCode = `CRCEN_SZ_BYTE;
      else if (pstrb == 4'h3)
         sizeCode = `CRCEN_SZ_HALF;
      else
         sizeCode = `CRCEN_SZ_WORD;
   end

   // write readiness per target
   always @*
   begin
      // dma bursts stall only on full fifo
      if (sel == `CRCEN_SEL_DATA)
         writeReady = fifoInReady;
      else if ((sel == `CRCEN_SEL_MODE) || (sel == `CRCEN_SEL_SEED) ||
               (sel == `CRCEN_SEL_POLY))
         writeReady = ~busy;
      else
         writeReady = 1'b1;
   end

   // reads answer from the value registered in the previous cycle
   assign pready = pwrite ? writeReady : ((sel == `CRCEN_SEL_NONE) | rdOk_q);
   assign pslverr = access & (sel == `CRCEN_SEL_NONE);
   assign wrDone = access & pwrite & writeReady;

   // data writes enter the fifo tagged with their width
   assign fifoInValid = access & pwrite & (sel == `CRCEN_SEL_DATA);
   assign fifoInData = {sizeCode, pwdata};

   // ==========================================================================
   // read mux

   reg [31:0] sumOut;
   wire sumWide;

   // sum reverse and complement on read
   always @*
   begin
      sumOut = crc_q;
      if (mode_q[`CRCEN_MODE_SREV])
         sumOut = sumWide ? rev32(crc_q) : (rev32(crc_q) >> 16);
      if (mode_q[`CRCEN_MODE_SCPL])
         sumOut = sumOut ^ (sumWide ? 32'hFFFFFFFF : 32'h0000FFFF);
   end

   always @*
   begin
      rdMux = 32'h00000000;
      if (sel == `CRCEN_SEL_MODE)
         rdMux = {{(32-`CRCEN_MODE_W){1'b0}}, mode_q};
      else if (sel == `CRCEN_SEL_POLY)
         rdMux = poly_q;
      else if (sel == `CRCEN_SEL_SUM)
         rdMux = sumOut;
      else if (sel == `CRCEN_SEL_STATUS)
      begin
         rdMux[`CRCEN_STAT_BUSY] = busy;
         rdMux[`CRCEN_STAT_LVL_MSB:`CRCEN_STAT_LVL_LSB] = fifoLevel;
      end
   end

   // read data is a flop; a sum read only becomes ready once the engine drains
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         prdata <= 32'h00000000;
         rdOk_q <= 1'b0;
      end
      else
      begin
         prdata <= rdMux;
         rdOk_q <= psel & ~pwrite & ((sel != `CRCEN_SEL_SUM) | ~busy);
      end
   end

   // ==========================================================================
   // polynomial selection

   reg [31:0] activePoly;
   reg polyWide;

   always @*
   begin
      case (mode_q[`CRCEN_MODE_POLY_MSB:`CRCEN_MODE_POLY_LSB])
         `CRCEN_PSEL_CCITT:
         begin
            activePoly = `CRCEN_GEN_CCITT;
            polyWide = 1'b0;
         end
         `CRCEN_PSEL_CRC16:
         begin
            activePoly = `CRCEN_GEN_CRC16;
            polyWide = 1'b0;
         end
         `CRCEN_PSEL_CRC32:
         begin
            activePoly = `CRCEN_GEN_CRC32;
            polyWide = 1'b1;
         end
         default:
         begin
            activePoly = poly_q;
            polyWide = mode_q[`CRCEN_MODE_CWIDE];
         end
      endcase
   end

   assign sumWide = polyWide;

   // ==========================================================================
   // byte engine

   wire doFold;
   wire [7:0] rawByte;
   reg [7:0] stepByte;
   wire [31:0] stepCrc;
   wire [31:0] fifoWord;
   wire [1:0] fifoSize;

   assign fifoWord = fifoOutData[31:0];
   assign fifoSize = fifoOutData[33:32];

   // a new word is popped only when the previous one is fully folded
   assign fifoOutReady = (left_q == 3'h0);
   // the first byte folds in the same cycle as the pop, so a byte costs one cycle
   assign doFold = (left_q != 3'h0) | fifoOutValid;
   assign rawByte = (left_q != 3'h0) ? cur_q[7:0] : fifoWord[7:0];

   always @*
   begin
      stepByte = rawByte ^ (mode_q[`CRCEN_MODE_DCPL] ? 8'hFF : 8'h00);
      if (mode_q[`CRCEN_MODE_DREV])
         stepByte = {stepByte[0], stepByte[1], stepByte[2], stepByte[3], stepByte[4], stepByte[5], stepByte[6], stepByte[7]};
   end

   crcen_step uStep
   (
      .crcIn(crc_q),
      .dataIn(stepByte),
      .poly(activePoly),
      .wide(polyWide),
      .crcOut(stepCrc)
   );

   // next state of the accumulator and the byte sequencer
   always @*
   begin
      crc_d = crc_q;
      cur_d = cur_q;
      left_d = left_q;
      if (wrDone && (sel == `CRCEN_SEL_SEED))
      begin
         crc_d = pwdata & (polyWide ? 32'hFFFFFFFF : 32'h0000FFFF);
      end
      else if (doFold)
      begin
         crc_d = stepCrc;
         if (left_q != 3'h0)
         begin
            cur_d = {8'h00, cur_q[23:8]};
            left_d = left_q - 3'h1;
         end
         else
         begin
            cur_d = fifoWord[31:8];
            if (fifoSize == `CRCEN_SZ_BYTE)
               left_d = 3'h0;
            else if (fifoSize == `CRCEN_SZ_HALF)
               left_d = 3'h1;
            else
               left_d = 3'h3;
         end
      end
   end

   // ==========================================================================
   // registers

   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mode_q <= `CRCEN_MODE_RST;
         poly_q <= `CRCEN_POLY_RST;
         crc_q <= `CRCEN_SEED_RST;
         cur_q <= 24'h000000;
         left_q <= 3'h0;
      end
      else
      begin
         crc_q <= crc_d;
         cur_q <= cur_d;
         left_q <= left_d;
         if (wrDone && (sel == `CRCEN_SEL_MODE))
            mode_q <= pwdata[`CRCEN_MODE_W-1:0];
         if (wrDone && (sel == `CRCEN_SEL_POLY))
            poly_q <= pwdata;
      end
   end

   // ==========================================================================
   // data fifo

   crcen_fifo
   #(
      .WIDTH(`CRCEN_FIFO_W),
      .DEPTH(`CRCEN_FIFO_D),
      .AW(`CRCEN_FIFO_AW)
   )
   uFifo
   (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .inValid(fifoInValid),
      .inReady(fifoInReady),
      .inData(fifoInData),
      .outValid(fifoOutValid),
      .outReady(fifoOutReady),
      .outData(fifoOutData),
      .level(fifoLevel)
   );

endmodule
`default_nettype wire

// file: core/crcen_fifo.v
// flip-flop fifo holding data words in front of the crc byte engine
`timescale 1ns/1ps
`default_nettype none

module crcen_fifo
#(
   parameter WIDTH = 34,
   parameter DEPTH = 8,
   parameter AW = 3
)
(
   input wire ref_clk,
   input wire rst_n,
   input wire inValid,
   output wire inReady,
   input wire [WIDTH-1:0] inData,
   output wire outValid,
   input wire outReady,
   output wire [WIDTH-1:0] outData,
   output wire [AW:0] level
);

   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW-1:0] wrPtr_q;
   reg [AW-1:0] rdPtr_q;
   reg [AW:0] count_q;
   wire push;
   wire pop;

   // full and empty come straight from the count, so both are exact
   assign inReady = (count_q != DEPTH[AW:0]);
   assign outValid = (count_q != {(AW+1){1'b0}});
   assign push = inValid & inReady;
   assign pop = outValid & outReady;
   assign outData = mem[rdPtr_q];
   assign level = count_q;

   // storage has no reset; only slots below the count are ever read
   always @(posedge ref_clk)
   begin
      if (push)
      begin
         mem[wrPtr_q] <= inData;
      end
   end

   // pointers wrap naturally because depth is a power of two
   always @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wrPtr_q <= {AW{1'b0}};
         rdPtr_q <= {AW{1'b0}};
         count_q <= {(AW+1){1'b0}};
      end
      else
      begin
         if (push)
         begin
            wrPtr_q <= wrPtr_q + 1'b1;
         end
         if (pop)
         begin
            rdPtr_q <= rdPtr_q + 1'b1;
         end
         if (push && !pop)
         begin
            count_q <= count_q + 1'b1;
         end
         else if (pop && !push)
         begin
            count_q <= count_q - 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

// file: core/crcen_step.v
// one byte folded into a crc accumulator, msb first, eight shift stages
`timescale 1ns/1ps
`default_nettype none

module crcen_step
(
   input wire [31:0] crcIn,
   input wire [7:0] dataIn,
   input wire [31:0] poly,
   input wire wide,
   output wire [31:0] crcOut
);

   wire [31:0] chain [0:8];
   wire [31:0] widthMask;

   // narrow sums keep their upper half at zero
   assign widthMask = wide ? 32'hFFFFFFFF : 32'h0000FFFF;
   assign chain[0] = crcIn & widthMask;

   // each stage takes one data bit, bit 7 first
   genvar i;
   generate
      for (i = 0; i < 8; i = i + 1)
      begin : gStage
         wire topBit;
         wire feedBack;
         assign topBit = wide ? chain[i][31] : chain[i][15];
         assign feedBack = topBit ^ dataIn[7-i];
         assign chain[i+1] = ({chain[i][30:0], 1'b0} ^ (feedBack ? poly : 32'h00000000))
            & widthMask;
      end
   endgenerate

   assign crcOut = chain[8];

endmodule
`default_nettype wire

// file: shared/crcen_map.vh
// register offsets, field positions, reset values and generators of the crc engine
`ifndef CRCEN_MAP_VH
`define CRCEN_MAP_VH

// ==========================================================================
// register byte offsets on the apb bus
`define CRCEN_OFS_MODE 12'h000
`define CRCEN_OFS_SEED 12'h004
`define CRCEN_OFS_SUM 12'h008
`define CRCEN_OFS_DATA 12'h00C
`define CRCEN_OFS_POLY 12'h010
`define CRCEN_OFS_STATUS 12'h014

// ==========================================================================
// internal register select codes
`define CRCEN_SEL_MODE 3'h0
`define CRCEN_SEL_SEED 3'h1
`define CRCEN_SEL_SUM 3'h2
`define CRCEN_SEL_DATA 3'h3
`define CRCEN_SEL_POLY 3'h4
`define CRCEN_SEL_STATUS 3'h5
`define CRCEN_SEL_NONE 3'h7

// ==========================================================================
// mode register fields
`define CRCEN_MODE_POLY_LSB 0
`define CRCEN_MODE_POLY_MSB 1
`define CRCEN_MODE_DREV 2
`define CRCEN_MODE_DCPL 3
`define CRCEN_MODE_SREV 4
`define CRCEN_MODE_SCPL 5
`define CRCEN_MODE_CWIDE 6
`define CRCEN_MODE_W 7

// polynomial select codes
`define CRCEN_PSEL_CCITT 2'h0
`define CRCEN_PSEL_CRC16 2'h1
`define CRCEN_PSEL_CRC32 2'h2
`define CRCEN_PSEL_CUSTOM 2'h3

// ==========================================================================
// status register fields
`define CRCEN_STAT_BUSY 0
`define CRCEN_STAT_LVL_LSB 4
`define CRCEN_STAT_LVL_MSB 7

// ==========================================================================
// reset values
`define CRCEN_MODE_RST 7'h00
`define CRCEN_SEED_RST 32'h00000000
`define CRCEN_POLY_RST 32'h00000000

// ==========================================================================
// fixed generators, implicit top term left out
`define CRCEN_GEN_CCITT 32'h00001021
`define CRCEN_GEN_CRC16 32'h00008005
`define CRCEN_GEN_CRC32 32'h04C11DB7

// ==========================================================================
// data fifo entry: size code over the data word
`define CRCEN_SZ_BYTE 2'h0
`define CRCEN_SZ_HALF 2'h1
`define CRCEN_SZ_WORD 2'h2
`define CRCEN_FIFO_W 34
`define CRCEN_FIFO_D 8
`define CRCEN_FIFO_AW 3

`endif

// file: testbench/crcen_apb_host.sv
// apb master standing in for the processor or dma controller
`timescale 1ns/1ps
`default_nettype none

// ==========================================
// bus master
module crcen_apb_host
(
   input wire ref_clk,
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [11:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   // quiet bus at time zero
   initial
   begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h00000000;
      pstrb = 4'h0;
   end

   // back-to-back transfers: psel stays high so the next setup follows at once
   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] s, output logic [31:0] rd, output logic err);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge ref_clk);
      penable <= 1'b1;
      // ready, read data and error are taken at the rising edge that ends the access;
      // no cycle limit here, a wait that never ends is left to the bench watchdog
      do
      begin
         @(posedge ref_clk);
      end
      while (!pready);
      rd = prdata;
      err = pslverr;
      penable <= 1'b0;
   endtask

   // released bus shows no stale address or data
   task automatic idle();
      psel <= 1'b0;
      paddr <= ~paddr;
      pwdata <= ~pwdata;
      @(posedge ref_clk);
   endtask
endmodule
`default_nettype wire

// file: testbench/crcen_engine_asserts.sv
// checker on the apb ports of the crc engine
`timescale 1ns/1ps
`default_nettype none
`include "crcen_map.vh"

// ==========================================
// bus timing checks
module crcen_engine_asserts
(
   input wire ref_clk,
   input wire rst_n,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [3:0] pstrb,
   input wire [31:0] prdata,
   input wire pready,
   input wire pslverr
);
   logic [7:0] pend_q;
   logic [7:0] pend_d;
   logic [2:0] szB;
   wire access = psel && penable;
   wire mapped = paddr[11:5] == 7'h00 && paddr[1:0] == 2'h0 && paddr[4:2] <= 3'h5;
   wire dataWr = access && pready && pwrite && paddr == `CRCEN_OFS_DATA;
   wire cfgAdr = paddr == `CRCEN_OFS_MODE || paddr == `CRCEN_OFS_SEED || paddr == `CRCEN_OFS_POLY;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   // bytes still to fold; a lower bound, as the engine folds one byte a cycle at best
   assign szB = pstrb == 4'h1 ? 3'h1 : (pstrb == 4'h3 ? 3'h2 : 3'h4);
   assign pend_d = pend_q - {7'h00, pend_q != 8'h00} + (dataWr ? {5'h00, szB} : 8'h00);
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         pend_q <= 8'h00;
      else
         pend_q <= pend_d;

   sequence sumSetup;
      psel && !penable && !pwrite && paddr == `CRCEN_OFS_SUM;
   endsequence
   sequence cfgAccess;
      access && pwrite && cfgAdr;
   endsequence

   a_unmapped_err: assert property (access && !mapped |-> pslverr && pready)
      else $error("unmapped access without error");
   a_mapped_clean: assert property (access && mapped |-> !pslverr)
      else $error("error on mapped access");
   a_sum_stall: assert property (access && !pwrite && paddr == `CRCEN_OFS_SUM && pend_q > 8'h01 |-> !pready)
      else $error("sum read answered while folding");
   a_cfg_stall: assert property (cfgAccess ##0 pend_q > 8'h01 |-> !pready)
      else $error("config write answered while folding");
   a_sum_bound: assert property (sumSetup ##1 access |-> ##[0:60] pready)
      else $error("sum read never answered");
   a_idle_read: assert property (sumSetup ##0 pend_q == 8'h00 ##1 access |-> pready)
      else $error("idle sum read delayed");
   a_byte_fast: assert property (sumSetup ##0 pend_q == 8'h01 ##1 access |-> ##[0:12] pready)
      else $error("sum read after byte too slow");
   a_data_accept: assert property (access && pwrite && paddr == `CRCEN_OFS_DATA && pend_q == 8'h00 |-> pready)
      else $error("data write refused while idle");
endmodule

bind crcen_engine crcen_engine_asserts u_chk (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// file: testbench/crcen_engine_tb_top.sv
// self-checking bench for the crc engine
`timescale 1ns/1ps
`default_nettype none
`include "crcen_map.vh"

module crcen_engine_tb_top;
   logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd, acc;
   logic [3:0] pstrb;
   logic [31:0] rngQ = 32'h0000F276;
   int nFail, testsRun;

   crcen_apb_host u_host (.ref_clk(ref_clk), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   crcen_engine u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr));

   // ==========================================
   // reference model
   function automatic logic [31:0] rnd();
      rngQ ^= rngQ << 13;
      rngQ ^= rngQ >> 17;
      rngQ ^= rngQ << 5;
      return rngQ;
   endfunction
   function automatic logic wide(logic [6:0] m);
      return m[1:0] == 2'h2 || (m[1:0] == 2'h3 && m[6]);
   endfunction
   function automatic logic [31:0] rev(logic [31:0] c, int n);
      logic [31:0] r;
      r = 32'h00000000;
      for (int k = 0; k < n; k++)
         r[k] = c[n - 1 - k];
      return r;
   endfunction
   function automatic logic [31:0] fold(logic [31:0] c, logic [7:0] b, logic [6:0] m,
      logic [31:0] p);
      logic [31:0] g;
      logic [7:0] x;
      logic w;
      w = wide(m);
      g = m[1:0] == 2'h0 ? 32'h00001021 : m[1:0] == 2'h1 ? 32'h00008005 :
         m[1:0] == 2'h2 ? 32'h04C11DB7 : p;
      x = m[2] ? rev({24'h000000, b}, 8) : b;
      x = m[3] ? ~x : x;
      c = c ^ (w ? {x, 24'h000000} : {16'h0000, x, 8'h00});
      for (int k = 0; k < 8; k++)
         c = (c << 1) ^ ((w ? c[31] : c[15]) ? g : 32'h00000000);
      return w ? c : {16'h0000, c[15:0]};
   endfunction
   function automatic logic [31:0] sumOut(logic [31:0] c, logic [6:0] m);
      c = m[4] ? rev(c, wide(m) ? 32 : 16) : c;
      c = m[5] ? ~c : c;
      return wide(m) ? c : {16'h0000, c[15:0]};
   endfunction

   // ==========================================
   // bus helpers and reporting
   task automatic bw(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      u_host.xfer(1'b1, a, d, s, rd, err);
   endtask
   task automatic br(input logic [11:0] a);
      u_host.xfer(1'b0, a, 32'h00000000, 4'h0, rd, err);
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      testsRun++;
      if (got !== exp)
      begin
         nFail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic endOfTest();
      $display("comparisons %0d mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // 25 MHz clock
   initial
   begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   // hang guard, well beyond the under two thousand cycles the run needs
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      nFail++;
      endOfTest();
   end

   // main sequence
   initial
   begin
      logic [6:0] m;
      logic [31:0] p, d;
      logic [3:0] s;
      int k;
      rst_n = 1'b0;
      nFail = 0;
      testsRun = 0;
      repeat (2) @(posedge ref_clk);
      rst_n <= 1'b1;
      @(posedge ref_clk);
      br(`CRCEN_OFS_MODE);
      chk("mode reset", 32'h00000000, rd);
      br(`CRCEN_OFS_POLY);
      chk("poly reset", 32'h00000000, rd);
      br(`CRCEN_OFS_SUM);
      chk("sum reset", 32'h00000000, rd);
      br(12'h018);
      chk("unmapped error", 32'h00000001, {31'h0, err});
      // every code once per four rounds; round 0 writes twelve words back to back, round 1 is one byte
      for (int i = 0; i < 24; i++)
      begin
         m = rnd();
         m[1:0] = i[1:0];
         p = rnd();
         acc = rnd();
         bw(`CRCEN_OFS_MODE, {25'h0, m}, 4'hF);
         bw(`CRCEN_OFS_POLY, p, 4'hF);
         bw(`CRCEN_OFS_SEED, acc, 4'hF);
         acc = wide(m) ? acc : {16'h0000, acc[15:0]};
         k = i == 0 ? 12 : i == 1 ? 1 : 1 + rnd() % 10;
         for (int j = 0; j < k; j++)
         begin
            d = rnd();
            s = i == 0 ? 4'hF : i == 1 ? 4'h1 : d[5:4] == 2'h0 ? 4'h1 : d[5:4] == 2'h1 ? 4'h3 : 4'hF;
            bw(`CRCEN_OFS_DATA, d, s);
            for (int b = 0; b < (s == 4'h1 ? 1 : s == 4'h3 ? 2 : 4); b++)
               acc = fold(acc, d[8 * b +: 8], m, p);
            if (d[0] && i > 1)
               u_host.idle();
         end
         if (i[0] && i > 1)
            bw(`CRCEN_OFS_MODE, {25'h0, m}, 4'hF);
         br(`CRCEN_OFS_SUM);
         chk("sum", sumOut(acc, m), rd);
         br(`CRCEN_OFS_STATUS);
         chk("status idle", 32'h00000000, {24'h0, rd[7:0]});
      end
      endOfTest();
   end
endmodule
`default_nettype wire
